// File: rtl/pfc_regs.sv
// Register bank: port selection, frequency counter and far receiver capabilities
//
// What this block does
// - Second-port select: primary-address writes reach port 1 and shared registers.
// - Second-port select: primary-address reads return port 1 and shared registers.
// - Second-port select makes the low GPIO control registers steer the far link.
// - First-port select: primary-address access reaches port 0 and shared registers.
// - Both selects set: reads from port 1, writes to both ports.
// - Secondary-address enable makes both port select bits ignored.
// - Secondary-address enable answers own address plus one, for port 1 and shared.
// - Writing the counter register starts a count over value times oscillator periods.
// - The count saturates at 0xff instead of wrapping.
// - Capabilities bit 5 sends the frequency training pattern.
// - Capabilities bit 4 sends the equalization training pattern.
// - Capabilities bit 3 holds far receiver dual-link support.
// - Capabilities bit 2 holds channel role: 0 primary, 1 secondary.
// - Capabilities bit 1 auto-loads from back channel once lock is seen.
// - Capabilities bit 0 auto-loads from back channel once lock is seen.
`default_nettype none
module pfc_regs
  import pfc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [6:0] device_id_i,
  input wire logic reg_req_i,
  input wire logic reg_wr_i,
  input wire logic [6:0] reg_dev_addr_i,
  input wire logic [7:0] reg_offset_i,
  input wire logic [7:0] reg_wdata_i,
  output logic reg_ack_o,
  output logic reg_hit_o,
  output logic [7:0] reg_rdata_o,
  input wire logic pixel_clk_i,
  input wire logic osc_clk_i,
  input wire logic [1:0] rx_lock_i,
  input wire logic [1:0] cap_load_i,
  input wire logic [3:0] cap_value0_i,
  input wire logic [3:0] cap_value1_i,
  output logic [GPIO_CTRL_NUM*8-1:0] local_gpio_ctrl_o,
  output logic [GPIO_CTRL_NUM*8-1:0] remote_gpio_ctrl_o,
  output logic [1:0] freq_pattern_transmit_o,
  output logic [1:0] equalizer_pattern_transmit_o,
  output logic [1:0] freeze_far_capabilities_o,
  output logic [7:0] far_caps0_o,
  output logic [7:0] far_caps1_o,
  output logic [7:0] port_select_o,
  output logic freq_busy_o
);
  // ==========================================================================
  // Address decoding helpers
  // Ports that a primary or secondary address access writes into
  function automatic logic [1:0] write_ports(input logic secondary, input logic [7:0] psel);
    logic [1:0] ports;
    ports = 2'b00;
    if (secondary) begin
      ports = 2'b10;
    end else if (psel[PSEL_SEC_ADDR_EN_BIT]) begin
      ports = 2'b01;
    end else begin
      // Both bits clear behaves as port 0 so the device never goes deaf
      ports[1] = psel[PSEL_SECOND_BIT];
      ports[0] = psel[PSEL_FIRST_BIT] | ~psel[PSEL_SECOND_BIT];
    end
    return ports;
  endfunction : write_ports

  // Port whose registers a read returns (1 means port 1)
  function automatic logic read_port(input logic secondary, input logic [7:0] psel);
    logic port;
    port = 1'b0;
    if (secondary) begin
      port = 1'b1;
    end else if (psel[PSEL_SEC_ADDR_EN_BIT]) begin
      port = 1'b0;
    end else begin
      port = psel[PSEL_SECOND_BIT];
    end
    return port;
  endfunction : read_port

  // ==========================================================================
  // Elaboration checks: the decode below assumes these layouts
  if (GPIO_CTRL_NUM != 4) begin : g_bad_gpio_num
    $error("gpio index is two bits wide and needs exactly four control registers");
  end
  if (CAP_AUTO_LSB + CAP_AUTO_W > CAP_EQ_PAT_BIT) begin : g_bad_auto_field
    $error("auto-loaded capability field overlaps the pattern bits");
  end
  if (ADDR_GPIO_CTRL_BASE + 8'(GPIO_CTRL_NUM) > ADDR_PORT_SELECT) begin : g_bad_gpio_map
    $error("gpio control window runs into the port select register");
  end

  // ==========================================================================
  // Offset decoding, shared by the write and read paths
  typedef enum logic [2:0] {
    PFC_OFF_NONE = 3'b000,
    PFC_OFF_PSEL = 3'b001,
    PFC_OFF_FREQ = 3'b010,
    PFC_OFF_CAPS = 3'b011,
    PFC_OFF_GPIO = 3'b100
  } pfc_off_e;

  function automatic pfc_off_e decode_offset(input logic [7:0] off);
    pfc_off_e kind;
    logic [7:0] rel;
    kind = PFC_OFF_NONE;
    rel = off - ADDR_GPIO_CTRL_BASE;
    if (off == ADDR_PORT_SELECT) begin
      kind = PFC_OFF_PSEL;
    end else if (off == ADDR_FREQ_COUNT) begin
      kind = PFC_OFF_FREQ;
    end else if (off == ADDR_FAR_CAPS) begin
      kind = PFC_OFF_CAPS;
    end else if ((off >= ADDR_GPIO_CTRL_BASE) && (rel < 8'(GPIO_CTRL_NUM))) begin
      kind = PFC_OFF_GPIO;
    end
    return kind;
  endfunction : decode_offset

  // ==========================================================================
  // Frequency counter
  pfc_freq_if fq ();
  pfc_freq_counter u_freq_counter (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .pixel_clk_i(pixel_clk_i),
    .osc_clk_i(osc_clk_i),
    .fq(fq.counter)
  );

  // ==========================================================================
  // Request decode
  logic [7:0] port_select;
  logic [7:0] far_caps [2];
  logic [7:0] gpio_ctrl [2][GPIO_CTRL_NUM];
  logic start_q;
  logic [7:0] interval_q;
  logic ack_q, hit_q;
  logic [7:0] rdata_q;

  logic [6:0] second_addr;
  logic primary_hit, secondary_hit, addr_hit;
  logic [1:0] wports;
  logic rport;
  assign second_addr = device_id_i + SECOND_ADDR_STEP;
  assign primary_hit = (reg_dev_addr_i == device_id_i);
  assign secondary_hit = port_select[PSEL_SEC_ADDR_EN_BIT] &&
                         (reg_dev_addr_i == second_addr);
  assign addr_hit = primary_hit | secondary_hit;
  assign wports = write_ports(secondary_hit, port_select);
  assign rport = read_port(secondary_hit, port_select);

  pfc_off_e off_kind;
  assign off_kind = decode_offset(reg_offset_i);

  logic is_gpio;
  logic [1:0] gpio_idx;
  logic [7:0] gpio_off;
  assign gpio_off = reg_offset_i - ADDR_GPIO_CTRL_BASE;
  assign is_gpio = (off_kind == PFC_OFF_GPIO);
  assign gpio_idx = gpio_off[1:0];

  logic do_write, do_read;
  assign do_write = reg_req_i & reg_wr_i & addr_hit;
  assign do_read = reg_req_i & ~reg_wr_i & addr_hit;

  // ==========================================================================
  // Next values of the register file
  logic [7:0] next_port_select;
  logic [7:0] next_far_caps [2];
  logic [7:0] next_gpio_ctrl [2][GPIO_CTRL_NUM];
  logic next_start;
  logic [7:0] next_interval;
  logic [3:0] cap_value [2];
  assign cap_value[0] = cap_value0_i;
  assign cap_value[1] = cap_value1_i;

  always_comb begin
    next_port_select = port_select;
    next_far_caps = far_caps;
    next_gpio_ctrl = gpio_ctrl;
    next_start = 1'b0;
    next_interval = interval_q;
    if (do_write) begin
      if (off_kind == PFC_OFF_PSEL) begin
        next_port_select = reg_wdata_i & PORT_SELECT_MASK;
      end
      if (off_kind == PFC_OFF_FREQ) begin
        next_start = 1'b1;
        next_interval = reg_wdata_i;
      end
      for (int p = 0; p < 2; p++) begin
        if (wports[p]) begin
          if (off_kind == PFC_OFF_CAPS) begin
            next_far_caps[p] = reg_wdata_i & FAR_CAPS_MASK;
          end
          // Port 1 copies drive the far link GPIOs
          if (is_gpio) begin
            next_gpio_ctrl[p][gpio_idx] = reg_wdata_i;
          end
        end
      end
    end
    // Back-channel load lands after any write in the same cycle, unless the
    // resulting freeze bit blocks it, so a frozen write is never undone
    for (int p = 0; p < 2; p++) begin
      if (cap_load_i[p] && rx_lock_i[p] && !next_far_caps[p][CAP_FREEZE_BIT]) begin
        next_far_caps[p][CAP_AUTO_LSB +: CAP_AUTO_W] = cap_value[p];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      port_select <= PORT_SELECT_RESET;
      far_caps[0] <= FAR_CAPS_RESET;
      far_caps[1] <= FAR_CAPS_RESET;
      for (int p = 0; p < 2; p++) begin
        for (int g = 0; g < GPIO_CTRL_NUM; g++) begin
          gpio_ctrl[p][g] <= GPIO_CTRL_RESET;
        end
      end
      start_q <= 1'b0;
      interval_q <= FREQ_COUNT_RESET;
    end else begin
      port_select <= next_port_select;
      far_caps <= next_far_caps;
      gpio_ctrl <= next_gpio_ctrl;
      start_q <= next_start;
      interval_q <= next_interval;
    end
  end

  assign fq.start = start_q;
  assign fq.interval = interval_q;

  // ==========================================================================
  // Read path, answered one cycle after the request
  logic next_ack, next_hit;
  logic [7:0] next_rdata;
  always_comb begin
    next_ack = reg_req_i;
    next_hit = reg_req_i & addr_hit;
    next_rdata = rdata_q;
    if (do_read) begin
      unique case (off_kind)
        PFC_OFF_PSEL: begin
          next_rdata = port_select;
        end
        PFC_OFF_FREQ: begin
          // Count is a flop in this domain, so a read never sees it mid-update
          next_rdata = fq.count;
        end
        PFC_OFF_CAPS: begin
          next_rdata = far_caps[rport];
        end
        PFC_OFF_GPIO: begin
          next_rdata = gpio_ctrl[rport][gpio_idx];
        end
        PFC_OFF_NONE: begin
          next_rdata = READ_UNMAPPED;
        end
        default: begin
          next_rdata = READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      hit_q <= 1'b0;
      rdata_q <= READ_UNMAPPED;
    end else begin
      ack_q <= next_ack;
      hit_q <= next_hit;
      rdata_q <= next_rdata;
    end
  end

  // ==========================================================================
  // Outputs, all taken from flops
  assign reg_ack_o = ack_q;
  assign reg_hit_o = hit_q;
  assign reg_rdata_o = rdata_q;
  assign port_select_o = port_select;
  assign far_caps0_o = far_caps[0];
  assign far_caps1_o = far_caps[1];
  assign freq_busy_o = fq.busy;

  genvar gi;
  generate
    for (gi = 0; gi < GPIO_CTRL_NUM; gi++) begin : g_gpio_out
      assign local_gpio_ctrl_o[gi*8 +: 8] = gpio_ctrl[0][gi];
      assign remote_gpio_ctrl_o[gi*8 +: 8] = gpio_ctrl[1][gi];
    end
    for (gi = 0; gi < 2; gi++) begin : g_pattern_out
      assign freq_pattern_transmit_o[gi] = far_caps[gi][CAP_FREQ_PAT_BIT];
      assign equalizer_pattern_transmit_o[gi] = far_caps[gi][CAP_EQ_PAT_BIT];
      assign freeze_far_capabilities_o[gi] = far_caps[gi][CAP_FREEZE_BIT];
    end
  endgenerate
endmodule : pfc_regs
`default_nettype wire

// File: rtl/pfc_pkg.sv
// Constants shared by the port select, frequency counter and capabilities logic
`default_nettype none
package pfc_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_GPIO_CTRL_BASE = 8'h0d;
  localparam logic [7:0] ADDR_PORT_SELECT = 8'h1e;
  localparam logic [7:0] ADDR_FREQ_COUNT = 8'h1f;
  localparam logic [7:0] ADDR_FAR_CAPS = 8'h20;
  localparam int GPIO_CTRL_NUM = 4;
  // ==========================================================================
  // Reset values and writable masks
  localparam logic [7:0] PORT_SELECT_RESET = 8'h01;
  localparam logic [7:0] PORT_SELECT_MASK = 8'h07;
  localparam logic [7:0] FREQ_COUNT_RESET = 8'h00;
  localparam logic [7:0] FAR_CAPS_RESET = 8'h00;
  localparam logic [7:0] FAR_CAPS_MASK = 8'hbf;
  localparam logic [7:0] GPIO_CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [7:0] FREQ_COUNT_MAX = 8'hff;
  localparam logic [6:0] SECOND_ADDR_STEP = 7'h01;
  // ==========================================================================
  // Field positions
  localparam int PSEL_FIRST_BIT = 0;
  localparam int PSEL_SECOND_BIT = 1;
  localparam int PSEL_SEC_ADDR_EN_BIT = 2;
  localparam int CAP_FREEZE_BIT = 7;
  localparam int CAP_FREQ_PAT_BIT = 5;
  localparam int CAP_EQ_PAT_BIT = 4;
  localparam int CAP_AUTO_LSB = 0;
  localparam int CAP_AUTO_W = 4;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_PERIOD_NS = 40;
  localparam int OSC_PERIOD_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MIN_SAMPLE_CYC = 3;

  typedef enum logic [0:0] {
    PFC_FC_IDLE = 1'b0,
    PFC_FC_RUN = 1'b1
  } pfc_fc_state_e;
endpackage : pfc_pkg
`default_nettype wire

// File: rtl/pfc_freq_if.sv
// Carrier between register bank and frequency counter
`default_nettype none
interface pfc_freq_if;
  logic start;
  logic [7:0] interval;
  logic [7:0] count;
  logic busy;
  modport ctrl (output start, output interval, input count, input busy);
  modport counter (input start, input interval, output count, output busy);
endinterface : pfc_freq_if
`default_nettype wire

// File: rtl/pfc_freq_counter.sv
// Pixel clock frequency counter timed by the oscillator clock
`default_nettype none
module pfc_freq_counter
  import pfc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic pixel_clk_i,
  input wire logic osc_clk_i,
  pfc_freq_if.counter fq
);
  // ==========================================================================
  // Synchronisers; both clocks are sampled as levels on the system clock.
  // Limitation: pixel clocks above about a third of 125 MHz alias.
  if (OSC_PERIOD_CYC < MIN_SAMPLE_CYC) begin : g_osc_too_fast
    $error("oscillator too fast to sample");
  end
  logic pix_meta, pix_sync, pix_last;
  logic osc_meta, osc_sync, osc_last;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pix_meta <= 1'b0;
      pix_sync <= 1'b0;
      pix_last <= 1'b0;
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_last <= 1'b0;
    end else begin
      pix_meta <= pixel_clk_i;
      pix_sync <= pix_meta;
      pix_last <= pix_sync;
      osc_meta <= osc_clk_i;
      osc_sync <= osc_meta;
      osc_last <= osc_sync;
    end
  end
  logic pix_rise, osc_rise;
  assign pix_rise = pix_sync & ~pix_last;
  assign osc_rise = osc_sync & ~osc_last;
  // ==========================================================================
  // Interval and count
  pfc_fc_state_e state, next_state;
  logic [7:0] remain, next_remain;
  logic [7:0] count, next_count;
  always_comb begin
    next_state = state;
    next_remain = remain;
    next_count = count;
    if (fq.start) begin
      next_count = FREQ_COUNT_RESET;
      next_remain = fq.interval;
      next_state = (fq.interval == 8'h00) ? PFC_FC_IDLE : PFC_FC_RUN;
    end else begin
      unique case (state)
        PFC_FC_IDLE: begin
        end
        PFC_FC_RUN: begin
          if (pix_rise && count != FREQ_COUNT_MAX) begin
            next_count = count + 8'h01;
          end
          if (osc_rise) begin
            next_remain = remain - 8'h01;
            if (remain == 8'h01) begin
              next_state = PFC_FC_IDLE;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= PFC_FC_IDLE;
      remain <= 8'h00;
      count <= FREQ_COUNT_RESET;
    end else begin
      state <= next_state;
      remain <= next_remain;
      count <= next_count;
    end
  end
  assign fq.count = count;
  assign fq.busy = (state == PFC_FC_RUN);
endmodule : pfc_freq_counter
`default_nettype wire

// File: bench/pfc_regs_chk.sv
// Checker for the port select, frequency counter and capabilities bank
`default_nettype none
module pfc_regs_chk
  import pfc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [6:0] device_id_i,
  input wire logic reg_req_i,
  input wire logic reg_wr_i,
  input wire logic [6:0] reg_dev_addr_i,
  input wire logic [7:0] reg_offset_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_ack_o,
  input wire logic reg_hit_o,
  input wire logic [1:0] rx_lock_i,
  input wire logic [1:0] cap_load_i,
  input wire logic [3:0] cap_value0_i,
  input wire logic [1:0] freq_pattern_transmit_o,
  input wire logic [1:0] equalizer_pattern_transmit_o,
  input wire logic [1:0] freeze_far_capabilities_o,
  input wire logic [7:0] far_caps0_o,
  input wire logic [7:0] far_caps1_o,
  input wire logic [7:0] port_select_o,
  input wire logic freq_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================================
  // Address decode seen from outside
  logic prim;
  logic sec;
  assign prim = reg_dev_addr_i == device_id_i;
  assign sec = port_select_o[PSEL_SEC_ADDR_EN_BIT]
    && reg_dev_addr_i == device_id_i + SECOND_ADDR_STEP;
  a_ack_follows_req: assert property (reg_req_i |=> reg_ack_o)
    else $error("ack missing after request");
  a_no_stray_ack: assert property (!reg_req_i |=> !reg_ack_o)
    else $error("ack without request");
  a_hit_decode: assert property (reg_req_i |=> reg_hit_o == ($past(prim) || $past(sec)))
    else $error("hit does not match address decode");
  a_second_addr_port: assert property (reg_req_i && reg_wr_i && sec
    && reg_offset_i == ADDR_FAR_CAPS && !cap_load_i[1]
    |=> far_caps1_o == ($past(reg_wdata_i) & FAR_CAPS_MASK))
    else $error("secondary address write missed port 1");
  a_count_starts: assert property (reg_req_i && reg_wr_i && prim
    && reg_offset_i == ADDR_FREQ_COUNT && reg_wdata_i != 8'h00 |-> ##2 freq_busy_o)
    else $error("frequency interval did not start");
  // ==========================================================================
  // Capabilities
  a_freeze_holds: assert property (freeze_far_capabilities_o[0] && !reg_req_i
    |=> $stable(far_caps0_o))
    else $error("frozen capabilities changed");
  a_auto_load: assert property (cap_load_i[0] && rx_lock_i[0]
    && !freeze_far_capabilities_o[0] && !reg_req_i
    |=> far_caps0_o[3:0] == $past(cap_value0_i))
    else $error("capability auto-load missed");
  a_freq_pattern: assert property (reg_req_i && reg_wr_i && prim
    && (port_select_o[PSEL_SEC_ADDR_EN_BIT] || !port_select_o[PSEL_SECOND_BIT])
    && reg_offset_i == ADDR_FAR_CAPS
    |=> freq_pattern_transmit_o[0] == $past(reg_wdata_i[CAP_FREQ_PAT_BIT]))
    else $error("frequency pattern output wrong");
  a_eq_pattern: assert property (reg_req_i && reg_wr_i && sec
    && reg_offset_i == ADDR_FAR_CAPS
    |=> equalizer_pattern_transmit_o[1] == $past(reg_wdata_i[CAP_EQ_PAT_BIT]))
    else $error("equalization pattern output wrong");
endmodule : pfc_regs_chk
`default_nettype wire

// File: bench/pfc_far_model.sv
// Far receiver model: lock, capability updates, pixel and oscillator clocks
`default_nettype none
module pfc_far_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] send_i,
  input wire logic [3:0] caps_i,
  output logic [1:0] rx_lock_o,
  output logic [1:0] cap_load_o,
  output logic [3:0] cap_value0_o,
  output logic [3:0] cap_value1_o,
  output logic pixel_clk_o,
  output logic osc_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Fast enough to saturate a full interval, slow enough for the sampler
  parameter int PIX_HALF_NS = 16;
  initial begin
    pixel_clk_o = 1'b0;
    rx_lock_o = 2'b00;
    cap_load_o = 2'b00;
    cap_value0_o = 4'h0;
    cap_value1_o = 4'h0;
  end
  always #(PIX_HALF_NS) pixel_clk_o = ~pixel_clk_o;
  // Offset by 1 ns so oscillator edges never land on a system clock edge
  initial begin
    osc_clk_o = 1'b0;
    #1;
    forever #20 osc_clk_o = ~osc_clk_o;
  end
  always @(posedge clock_i) begin
    rx_lock_o <= sys_rst_i ? 2'b00 : 2'b11;
    cap_load_o <= send_i & rx_lock_o;
    // Junk outside an update so a stale value never passes as fresh
    cap_value0_o <= send_i[0] ? caps_i : ~cap_value0_o;
    cap_value1_o <= send_i[1] ? caps_i : ~cap_value1_o;
  end
endmodule : pfc_far_model
`default_nettype wire

// File: bench/pfc_regs_tb.sv
// Self-checking bench for the port select, frequency counter and capabilities bank
`default_nettype none
bind pfc_regs pfc_regs_chk u_chk (.clock_i, .sys_rst_i, .device_id_i, .reg_req_i,
  .reg_wr_i, .reg_dev_addr_i, .reg_offset_i, .reg_wdata_i, .reg_ack_o, .reg_hit_o,
  .rx_lock_i, .cap_load_i, .cap_value0_i, .freq_pattern_transmit_o,
  .equalizer_pattern_transmit_o, .freeze_far_capabilities_o, .far_caps0_o,
  .far_caps1_o, .port_select_o, .freq_busy_o);
module pfc_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pfc_pkg::*;
  localparam logic [6:0] ID = 7'h1a;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_req_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic [6:0] reg_dev_addr_i = ID;
  logic [7:0] reg_offset_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [1:0] send = 2'b00;
  logic [3:0] caps = 4'h0;
  logic reg_ack_o, reg_hit_o, freq_busy_o, pixel_clk_i, osc_clk_i;
  logic [7:0] reg_rdata_o, far_caps0_o, far_caps1_o, port_select_o;
  logic [1:0] rx_lock_i, cap_load_i, freq_pattern_transmit_o;
  logic [1:0] equalizer_pattern_transmit_o, freeze_far_capabilities_o;
  logic [3:0] cap_value0_i, cap_value1_i;
  logic [GPIO_CTRL_NUM*8-1:0] local_gpio_ctrl_o, remote_gpio_ctrl_o;
  int n_errors = 0;
  int n_tests = 0;
  always #4 clock_i = ~clock_i;
  pfc_regs dut (.clock_i, .sys_rst_i, .device_id_i(ID), .reg_req_i, .reg_wr_i,
    .reg_dev_addr_i, .reg_offset_i, .reg_wdata_i, .reg_ack_o, .reg_hit_o, .reg_rdata_o,
    .pixel_clk_i, .osc_clk_i, .rx_lock_i, .cap_load_i, .cap_value0_i, .cap_value1_i,
    .local_gpio_ctrl_o, .remote_gpio_ctrl_o, .freq_pattern_transmit_o,
    .equalizer_pattern_transmit_o, .freeze_far_capabilities_o, .far_caps0_o,
    .far_caps1_o, .port_select_o, .freq_busy_o);
  pfc_far_model far (.clock_i, .sys_rst_i, .send_i(send), .caps_i(caps),
    .rx_lock_o(rx_lock_i), .cap_load_o(cap_load_i), .cap_value0_o(cap_value0_i),
    .cap_value1_o(cap_value1_i), .pixel_clk_o(pixel_clk_i), .osc_clk_o(osc_clk_i));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [6:0] dev, input logic [7:0] off,
    input logic [7:0] wd, output logic hit, output logic [7:0] rd);
    reg_req_i = 1'b1;
    reg_wr_i = wr;
    reg_dev_addr_i = dev;
    reg_offset_i = off;
    reg_wdata_i = wd;
    @(posedge clock_i);
    #1;
    reg_req_i = 1'b0;
    reg_wdata_i = ~wd;
    chk("ack", 1'b1, reg_ack_o);
    hit = reg_hit_o;
    rd = reg_rdata_o;
    @(posedge clock_i);
    #1;
  endtask : acc
  task automatic wr(input logic [7:0] off, input logic [7:0] wd);
    logic h;
    logic [7:0] r;
    acc(1'b1, ID, off, wd, h, r);
    chk("write hit", 1'b1, h);
  endtask : wr
  task automatic rdc(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] exp);
    logic h;
    logic [7:0] r;
    acc(1'b0, dev, off, 8'h00, h, r);
    chk("read data", exp, r);
  endtask : rdc
  task automatic snd(input logic [1:0] p, input logic [3:0] v);
    send = p;
    caps = v;
    @(posedge clock_i);
    #1;
    send = 2'b00;
    @(posedge clock_i);
    #1;
  endtask : snd
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk("port select", PORT_SELECT_RESET, port_select_o);
    rdc(ID, ADDR_FREQ_COUNT, FREQ_COUNT_RESET);
    rdc(ID, ADDR_FAR_CAPS, FAR_CAPS_RESET);
    chk("caps1", FAR_CAPS_RESET, far_caps1_o);
  endtask : t_reset
  task automatic t_steer();
    wr(ADDR_PORT_SELECT, 8'h02);
    wr(ADDR_FAR_CAPS, 8'h13);
    chk("caps1", 8'h13, far_caps1_o);
    chk("caps0", 8'h00, far_caps0_o);
    rdc(ID, ADDR_FAR_CAPS, 8'h13);
    for (int g = 0; g < GPIO_CTRL_NUM; g++) begin
      wr(ADDR_GPIO_CTRL_BASE + 8'(g), 8'h50 + 8'(g));
    end
    chk("remote gpio", 32'h53525150, remote_gpio_ctrl_o);
    chk("local gpio", 32'h0, local_gpio_ctrl_o);
    wr(ADDR_PORT_SELECT, 8'h01);
    wr(ADDR_FAR_CAPS, 8'hff);
    rdc(ID, ADDR_FAR_CAPS, 8'hbf);
    wr(ADDR_PORT_SELECT, 8'h03);
    rdc(ID, ADDR_FAR_CAPS, 8'h13);
    wr(ADDR_FAR_CAPS, 8'h24);
    chk("caps both", 16'h2424, {far_caps1_o, far_caps0_o});
    wr(ADDR_PORT_SELECT, 8'h00);
    wr(ADDR_FAR_CAPS, 8'h18);
    rdc(ID, ADDR_FAR_CAPS, 8'h18);
    chk("patterns", 4'b1001, {freq_pattern_transmit_o, equalizer_pattern_transmit_o});
  endtask : t_steer
  task automatic t_second();
    logic h;
    logic [7:0] r;
    wr(ADDR_PORT_SELECT, 8'h0e);
    chk("port select", 8'h06, port_select_o);
    wr(ADDR_FAR_CAPS, 8'h01);
    rdc(ID, ADDR_FAR_CAPS, 8'h01);
    acc(1'b1, ID + 7'h01, ADDR_FAR_CAPS, 8'h02, h, r);
    chk("caps1", 8'h02, far_caps1_o);
    rdc(ID + 7'h01, ADDR_FAR_CAPS, 8'h02);
    acc(1'b0, ID + 7'h02, ADDR_FAR_CAPS, 8'h00, h, r);
    chk("miss hit", 1'b0, h);
    rdc(ID, 8'h30, READ_UNMAPPED);
    wr(ADDR_PORT_SELECT, 8'h01);
    acc(1'b0, ID + 7'h01, ADDR_FAR_CAPS, 8'h00, h, r);
    chk("off hit", 1'b0, h);
  endtask : t_second
  task automatic t_freq(input logic [7:0] n, input logic [7:0] lo, input logic [7:0] hi);
    logic h;
    logic [7:0] r;
    wr(ADDR_FREQ_COUNT, n);
    @(posedge clock_i);
    #1;
    chk("busy", n != 8'h00, freq_busy_o);
    for (int i = 0; i < 3000 && freq_busy_o !== 1'b0; i++) begin
      @(posedge clock_i);
      #1;
    end
    chk("busy end", 1'b0, freq_busy_o);
    acc(1'b0, ID, ADDR_FREQ_COUNT, 8'h00, h, r);
    n_tests++;
    if ($isunknown(r) || r < lo || r > hi) begin
      n_errors++;
      $display("unexpected freq count: expected %0d..%0d, seen %h", lo, hi, r);
    end
  endtask : t_freq
  task automatic t_caps();
    wr(ADDR_FAR_CAPS, 8'h00);
    snd(2'b01, 4'ha);
    chk("caps0", 8'h0a, far_caps0_o);
    wr(ADDR_FAR_CAPS, 8'h81);
    snd(2'b01, 4'h6);
    chk("caps0", 8'h81, far_caps0_o);
    chk("freeze", 2'b01, freeze_far_capabilities_o);
    snd(2'b10, 4'h5);
    chk("caps1", 8'h05, far_caps1_o);
  endtask : t_caps
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_steer();
    t_second();
    t_freq(8'd10, 8'd11, 8'd14);
    t_freq(8'd0, 8'd0, 8'd0);
    t_freq(8'hff, FREQ_COUNT_MAX, FREQ_COUNT_MAX);
    t_caps();
    stop_test();
  end
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule : pfc_regs_tb
`default_nettype wire
